// ==== tss_map.svh ====
// Constants of the sensor serial slave port: address layout, bit counts, fill byte.
// Assumes nothing; included by bare name from the package, the slave module and the bench top.
`ifndef TSS_MAP_SVH
`define TSS_MAP_SVH

// Address byte layout
`define TSS_ADDR_W 7
`define TSS_STRAP_W 3
`define TSS_TYPE_W 4
`define TSS_RW_BIT 0
// Device type prefix, arbitrary neutral value
`define TSS_TYPE_DEFAULT 4'h5
// Bits per byte and last bit index
`define TSS_BYTE_W 8
`define TSS_LAST_BIT 3'h7
// Byte sent when no read data is waiting
`define TSS_FILL_BYTE 8'hFF
// Buffer depth
`define TSS_BUF_DEPTH 2

`endif

// ==== tss_pkg.sv ====
// Types of the sensor serial slave port.
// Assumes tss_map.svh sits in the same folder.
`include "tss_map.svh"

package tss_pkg;
    // Serial link states
    typedef enum logic [2:0] {
        TSS_IDLE,
        TSS_ADDR,
        TSS_ACK,
        TSS_WRITE,
        TSS_READ,
        TSS_RDACK
    } tss_state_type;
    // One byte of the stream
    typedef logic [`TSS_BYTE_W-1:0] tss_byte_type;
endpackage

// ==== tss_stream_if.sv ====
// Byte stream carrier with valid and ready between the port's own modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface tss_stream_if;
    import tss_pkg::*;
    tss_byte_type data; // Byte on offer
    logic valid; // Byte is on offer
    logic ready; // Receiver takes it
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

`default_nettype wire

// ==== tss_buf.sv ====
// Two-entry byte buffer: head and tail registers, head feeds the drain side.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module tss_buf
    import tss_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    tss_stream_if.snk fill,
    tss_stream_if.src drain
);
    tss_byte_type head_reg; // Oldest byte
    tss_byte_type tail_reg; // Second byte
    logic [1:0] count_reg; // Bytes held
    logic push; // Byte enters
    logic pop; // Byte leaves
    logic valid_reg; // Head holds a byte; a flop so the port sees a register

    // Only two entries are served; any other depth is refused at elaboration
    if (`TSS_BUF_DEPTH != 2) begin : g_depth_chk
        $error("tss_buf serves two entries only");
    end

    assign push = fill.valid && fill.ready;
    assign pop = drain.valid && drain.ready;
    // Ready from the count, valid from its own register
    assign fill.ready = (count_reg != 2'h2);
    assign drain.valid = valid_reg;
    assign drain.data = head_reg;

    // Occupancy
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_reg <= 2'h0;
            valid_reg <= 1'b0;
        end else if (push && !pop) begin
            count_reg <= count_reg + 2'h1;
            valid_reg <= 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 2'h1;
            valid_reg <= (count_reg == 2'h2);
        end
    end

    // Storage; a pop shifts the tail forward so the head stays a register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            head_reg <= 8'h00;
            tail_reg <= 8'h00;
        end else begin
            if (pop) begin
                head_reg <= (count_reg == 2'h2) ? tail_reg : fill.data;
            end else if (push && count_reg == 2'h0) begin
                head_reg <= fill.data;
            end
            if (push && ((count_reg == 2'h1 && !pop) || count_reg == 2'h2)) begin
                tail_reg <= fill.data;
            end
        end
    end
endmodule // tss_buf

`default_nettype wire

// ==== tss_slave.sv ====
// Two-wire serial slave port of a temperature sensor, with its open-drain alarm pin.
// Assumes bus pins arrive asynchronously and are oversampled by mclk (link clock is slow);
// alarm level and configuration bits come from logic on mclk.
//
// Operation
// [RULE1] Alarm active-low at reset, polarity bit flips
// [RULE2] Alarm comparator or interrupt by mode bit
// [RULE3] Host keeps shared alarms active-low
// [RULE4] Host may query alert response address; the port NACKs it as a foreign address
// [RULE5] Straps give three address low bits
// [RULE6] Floating straps read zero, tie firmly
// [RULE7] Device is slave only, master controls
// [RULE8] Sample on SCL rise, drive after fall
// [RULE9] Bytes move MSB first, bit per clock
// [RULE10] Ninth clock carries acknowledge bit
// [RULE11] Master clocks bytes without gaps
// [RULE12] SDA changes only while SCL low
// [RULE13] Any number of bytes per transfer
// [RULE14] Idle only when both lines high
// [RULE15] Ignore bus until start seen
// [RULE16] Stop ends transfer, back to idle
// [RULE17] Repeated start begins new operation
// [RULE18] Drive ACK low over ninth clock
// [RULE19] Master NACK ends read, release SDA
// [RULE20] NACK invalid writes
// [RULE21] Address mismatch: NACK and idle
// [RULE22] Last address bit: one means read
// [RULE23] Start or stop mid-byte abandons byte
// [RULE24] Release SDA unless driving ack/data
`timescale 1ns/1ps
`default_nettype none
`include "tss_map.svh"

module tss_slave
    import tss_pkg::*;
#(
    parameter logic [`TSS_TYPE_W-1:0] DEV_TYPE = `TSS_TYPE_DEFAULT // Arbitrary value
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [`TSS_STRAP_W-1:0] addr_strap_pins,
    input wire logic alarm_polarity,
    input wire logic alarm_mode_select,
    input wire logic alarm_event,
    output logic alarm_out,
    output logic alarm_oe,
    input wire logic write_protect,
    output tss_byte_type rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire tss_byte_type tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic bus_busy
);
    // Synchroniser stages
    logic scl_m_reg, scl_s_reg, scl_d_reg; // SCL first, second, delayed
    logic sda_m_reg, sda_s_reg, sda_d_reg; // SDA first, second, delayed
    logic [`TSS_STRAP_W-1:0] strap_m_reg, strap_s_reg; // Strap synchroniser
    // Bus events
    logic scl_rise, scl_fall, start_det, stop_det;
    // Link state
    tss_state_type state_reg; // Current phase of the transfer
    logic [2:0] bit_reg; // Bits done in the current byte
    logic byte_done_reg; // Eighth bit sampled, waiting for the fall
    tss_byte_type shift_reg; // Byte in or out
    logic read_reg; // Transfer direction is read
    logic addr_phase_reg; // Acknowledge belongs to the address byte
    logic ack_reg; // Device acknowledges the byte
    logic nack_seen_reg; // Master refused the last read byte
    logic sda_oe_reg; // Pulling SDA low
    logic tx_ready_reg; // Read byte taken
    logic busy_reg; // Between start and stop
    // Alarm
    logic alarm_act_reg; // Alarm asserted, before polarity
    logic alarm_ev_d_reg; // Alarm level last cycle
    logic alarm_oe_reg; // Alarm pin pulled low
    logic match; // Address byte is ours
    logic rd_clear; // Read addressing clears an interrupt alarm
    // Receive stream into the buffer
    tss_stream_if rx_in ();
    tss_stream_if rx_buf_out ();

    // [RULE7] SCL only sampled, never driven; two flops per pin, third for edges
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            scl_m_reg <= 1'b1;
            scl_s_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_m_reg <= 1'b1;
            sda_s_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_m_reg <= scl_in;
            scl_s_reg <= scl_m_reg;
            scl_d_reg <= scl_s_reg;
            sda_m_reg <= sda_in;
            sda_s_reg <= sda_m_reg;
            sda_d_reg <= sda_s_reg;
        end
    end

    // [RULE6] Straps resynchronised; a floating pin is held low outside
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            strap_m_reg <= 3'h0;
            strap_s_reg <= 3'h0;
        end else begin
            strap_m_reg <= addr_strap_pins;
            strap_s_reg <= strap_m_reg;
        end
    end

    assign scl_rise = scl_s_reg && !scl_d_reg;
    assign scl_fall = !scl_s_reg && scl_d_reg;
    // [RULE12] SDA moving while SCL high is a start or stop
    assign start_det = scl_s_reg && scl_d_reg && sda_d_reg && !sda_s_reg;
    assign stop_det = scl_s_reg && scl_d_reg && !sda_d_reg && sda_s_reg;
    // [RULE5] Type prefix plus straps; the low bit is direction
    assign match = (shift_reg[7:1] == {DEV_TYPE, strap_s_reg});

    // Busy flag: cleared by a stop, or while the state is idle with both lines high
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            busy_reg <= 1'b0;
        end else if (start_det) begin
            busy_reg <= 1'b1;
        // [RULE14] Idle needs both lines high
        end else if (stop_det || (state_reg == TSS_IDLE && scl_s_reg && sda_s_reg)) begin
            busy_reg <= 1'b0;
        end
    end

    // Transfer state machine and bit shifting
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_reg <= TSS_IDLE;
            bit_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            shift_reg <= 8'h00;
            read_reg <= 1'b0;
            addr_phase_reg <= 1'b0;
            ack_reg <= 1'b0;
            nack_seen_reg <= 1'b0;
        // [RULE15] Start from any state; [RULE17] [RULE23] a mid-byte start resynchronises
        end else if (start_det) begin
            state_reg <= TSS_ADDR;
            bit_reg <= 3'h0;
            byte_done_reg <= 1'b0;
            nack_seen_reg <= 1'b0;
        // [RULE16] Stop ends everything
        end else if (stop_det) begin
            state_reg <= TSS_IDLE;
            bit_reg <= 3'h0;
            byte_done_reg <= 1'b0;
        end else begin
            case (state_reg)
                // Receiving address or write byte
                TSS_ADDR, TSS_WRITE: begin
                    // [RULE8] [RULE9] Sample on the rise, MSB first
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_s_reg};
                        bit_reg <= bit_reg + 3'h1;
                        byte_done_reg <= (bit_reg == `TSS_LAST_BIT);
                    end else if (scl_fall && byte_done_reg) begin
                        // [RULE10] Ninth clock follows the eighth bit
                        byte_done_reg <= 1'b0;
                        state_reg <= TSS_ACK;
                        addr_phase_reg <= (state_reg == TSS_ADDR);
                        if (state_reg == TSS_ADDR) begin
                            // [RULE21] Only our address is answered
                            ack_reg <= match;
                            // [RULE22] Direction from the last bit
                            read_reg <= shift_reg[`TSS_RW_BIT];
                        end else begin
                            // [RULE20] Refused writes and a full buffer get NACK
                            ack_reg <= !write_protect && rx_in.ready;
                        end
                    end
                end
                // Acknowledge clock, ended by its falling edge
                TSS_ACK: begin
                    if (scl_fall) begin
                        if (!ack_reg) begin
                            // [RULE21] Mismatch or refusal: ignore until next start
                            state_reg <= TSS_IDLE;
                        end else if (addr_phase_reg && read_reg) begin
                            state_reg <= TSS_READ;
                            shift_reg <= tx_valid ? tx_data : `TSS_FILL_BYTE;
                        end else begin
                            // [RULE13] Any number of write bytes
                            state_reg <= TSS_WRITE;
                        end
                        bit_reg <= 3'h0;
                    end
                end
                // Sending a byte; bit 7 is on the line already
                TSS_READ: begin
                    if (scl_rise) begin
                        bit_reg <= bit_reg + 3'h1;
                        byte_done_reg <= (bit_reg == `TSS_LAST_BIT);
                    end else if (scl_fall) begin
                        if (byte_done_reg) begin
                            byte_done_reg <= 1'b0;
                            state_reg <= TSS_RDACK;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b1};
                        end
                    end
                end
                // Master answers the read byte
                TSS_RDACK: begin
                    if (scl_rise) begin
                        nack_seen_reg <= sda_s_reg;
                    end else if (scl_fall) begin
                        bit_reg <= 3'h0;
                        // [RULE19] NACK ends the read and releases the line
                        if (nack_seen_reg) begin
                            state_reg <= TSS_IDLE;
                        end else begin
                            // [RULE13] Next byte, as many as the master wants
                            state_reg <= TSS_READ;
                            shift_reg <= tx_valid ? tx_data : `TSS_FILL_BYTE;
                        end
                    end
                end
                TSS_IDLE: begin
                    bit_reg <= 3'h0;
                end
                default: begin
                    state_reg <= TSS_IDLE;
                end
            endcase
        end
    end

    // SDA drive; changes only on an SCL fall, or released at once on start/stop
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sda_oe_reg <= 1'b0;
        end else if (start_det || stop_det) begin
            sda_oe_reg <= 1'b0;
        end else if (scl_fall) begin
            case (state_reg)
                // [RULE18] ACK low across the whole ninth clock
                TSS_ADDR, TSS_WRITE: begin
                    sda_oe_reg <= byte_done_reg &&
                        ((state_reg == TSS_ADDR) ? match : (!write_protect && rx_in.ready));
                end
                // [RULE8] Next data bit after the fall; zero bits pull low
                TSS_ACK: begin
                    sda_oe_reg <= ack_reg && addr_phase_reg && read_reg &&
                        !(tx_valid ? tx_data[7] : 1'b1);
                end
                TSS_READ: begin
                    sda_oe_reg <= !byte_done_reg && !shift_reg[6];
                end
                TSS_RDACK: begin
                    sda_oe_reg <= !nack_seen_reg && !(tx_valid ? tx_data[7] : 1'b1);
                end
                // [RULE24] Line left to the master
                default: begin
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Read byte taken from the user once per loaded byte
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tx_ready_reg <= 1'b0;
        end else begin
            tx_ready_reg <= scl_fall && tx_valid && !start_det && !stop_det &&
                ((state_reg == TSS_ACK && ack_reg && addr_phase_reg && read_reg) ||
                 (state_reg == TSS_RDACK && !nack_seen_reg));
        end
    end

    // Accepted write byte enters the buffer as its acknowledge clock begins
    assign rx_in.data = shift_reg;
    assign rx_in.valid = (state_reg == TSS_WRITE) && scl_fall && byte_done_reg &&
        !write_protect && !start_det && !stop_det;
    assign rx_buf_out.ready = rx_ready;

    tss_buf u_buf (
        .mclk(mclk),
        .rst_n(rst_n),
        .fill(rx_in),
        .drain(rx_buf_out)
    );

    assign rd_clear = (state_reg == TSS_ACK) && scl_fall && ack_reg && addr_phase_reg && read_reg;

    // [RULE2] Comparator follows the level; interrupt latches until a read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alarm_act_reg <= 1'b0;
            alarm_ev_d_reg <= 1'b0;
        end else begin
            alarm_ev_d_reg <= alarm_event;
            if (!alarm_mode_select) begin
                alarm_act_reg <= alarm_event;
            end else if (alarm_event && !alarm_ev_d_reg) begin
                // New fault wins over a clear in the same cycle
                alarm_act_reg <= 1'b1;
            end else if (rd_clear) begin
                alarm_act_reg <= 1'b0;
            end
        end
    end

    // [RULE1] Active-low by default; polarity bit makes it active-high
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            alarm_oe_reg <= 1'b0;
        end else begin
            alarm_oe_reg <= alarm_act_reg ^ alarm_polarity;
        end
    end

    // Open-drain pins only ever pull low
    assign sda_out = 1'b0;
    assign alarm_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign alarm_oe = alarm_oe_reg;
    assign tx_ready = tx_ready_reg;
    assign bus_busy = busy_reg;
    assign rx_data = rx_buf_out.data;
    assign rx_valid = rx_buf_out.valid;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_alarm_pol;
        (!alarm_mode_select && !alarm_polarity && alarm_event)[*3] |-> alarm_oe;
    endproperty
    a_alarm_pol: assert property (p_alarm_pol) else $error("alarm not pulled low"); // RULE1

    property p_alarm_int;
        alarm_mode_select && alarm_act_reg && !rd_clear ##1 alarm_mode_select |-> alarm_act_reg;
    endproperty
    a_alarm_int: assert property (p_alarm_int) else $error("interrupt alarm dropped"); // RULE2

    property p_sda_timing;
        $rose(sda_oe) |-> $past(scl_fall);
    endproperty
    a_sda_timing: assert property (p_sda_timing) else $error("SDA driven off a fall"); // RULE8

    property p_idle_quiet;
        state_reg == TSS_IDLE && !start_det |=> state_reg == TSS_IDLE;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("left idle without start"); // RULE15

    property p_stop;
        stop_det |=> state_reg == TSS_IDLE && !sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not honoured"); // RULE16

    property p_ack_hold;
        state_reg == TSS_ACK && ack_reg && !addr_phase_reg && scl_s_reg && !stop_det && !start_det
            |-> sda_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("ACK not held"); // RULE18

    property p_rd_nack;
        state_reg == TSS_RDACK && nack_seen_reg && scl_fall && !start_det && !stop_det
            |=> state_reg == TSS_IDLE ##1 !sda_oe;
    endproperty
    a_rd_nack: assert property (p_rd_nack) else $error("read not ended by NACK"); // RULE19

    property p_mismatch;
        state_reg == TSS_ADDR && byte_done_reg && scl_fall && !match && !start_det && !stop_det
            |=> !sda_oe ##1 !sda_oe;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("foreign address acknowledged"); // RULE21

    property p_resync;
        start_det |=> state_reg == TSS_ADDR && bit_reg == 3'h0 && !sda_oe;
    endproperty
    a_resync: assert property (p_resync) else $error("start not resynchronised"); // RULE23

    property p_release;
        state_reg == TSS_IDLE && scl_fall |=> !sda_oe;
    endproperty
    a_release: assert property (p_release) else $error("SDA held while idle"); // RULE24

    c_write: cover property (state_reg == TSS_WRITE && rx_in.valid && rx_in.ready);
    c_read: cover property (state_reg == TSS_RDACK && scl_fall && !nack_seen_reg);
    c_full: cover property (state_reg == TSS_ACK && !ack_reg && !addr_phase_reg);
    c_alarm: cover property (alarm_mode_select && rd_clear && alarm_act_reg);
endmodule // tss_slave

`default_nettype wire

// ==== tss_master.sv ====
// Behavioural two-wire bus master that drives the slave port in the bench.
// Assumes the bench resolves sda from all pulls, with a pull-up.
`timescale 1ns/1ps
`default_nettype none

module tss_master (
    output var logic scl,
    output var logic sda_pull,
    input wire logic sda
);
    // Quarter of the 80 ns link period
    localparam time Q = 20ns;

    // Idle bus, clock stands still between frames
    // idle both high
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    // Start or repeated start, from idle or with scl low
    // master starts all
    task automatic start;
        #Q sda_pull = 1'b0;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b0;
    endtask

    // Stop: sda rises while scl high
    task automatic stop;
        #Q sda_pull = 1'b1;
        #Q scl = 1'b1;
        #Q sda_pull = 1'b0;
        #Q;
    endtask

    // One clock; the wire is sampled mid high phase
    // sda moves while scl low
    task automatic clk_bit(input logic pull, output logic seen);
        #Q sda_pull = pull;
        #Q scl = 1'b1;
        #Q seen = sda;
        #Q scl = 1'b0;
    endtask

    // Send n bits; a short count aborts the byte
    // msb first
    task automatic wr_byte(input logic [7:0] b, input int n, output logic ack);
        logic s;
        ack = 1'b0;
        for (int i = 7; i > 7 - n; i--) begin
            clk_bit(!b[i], s);
        end
        if (n == 8) begin
            clk_bit(1'b0, s);
            ack = !s;
        end
    endtask

    // Receive a byte, then ack or nack it
    // nack ends the read
    task automatic rd_byte(output logic [7:0] b, input logic nack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b0, b[i]);
        end
        clk_bit(!nack, s);
    endtask
endmodule // tss_master

`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench of the sensor serial slave port.
// Assumes tss_master as bus partner and a pull-up on sda.
`timescale 1ns/1ps
`default_nettype none
`include "tss_map.svh"

module tb_top;
    import tss_pkg::*;
    logic mclk, rst_n, scl, m_pull, sda_oe, sda_out, alarm_oe, alarm_out;
    logic polarity, mode, evt, wp, rx_valid, rx_ready, tx_valid, tx_ready, busy;
    logic [2:0] straps;
    tss_byte_type rx_data, tx_data;
    wire logic sda;
    int fail_count = 0;
    int n_tests = 0;
    tss_byte_type tx_taken = 8'h00; // Read bytes taken by the port
    localparam tss_byte_type ARA_READ = 8'h19; // Alert response address, read

    // Wired-AND bus: any pull wins, else the pull-up
    assign sda = !(m_pull || sda_oe);

    tss_slave DUT (.mclk(mclk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap_pins(straps),
        .alarm_polarity(polarity), .alarm_mode_select(mode), .alarm_event(evt),
        .alarm_out(alarm_out), .alarm_oe(alarm_oe), .write_protect(wp),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .bus_busy(busy));
    tss_master m (.scl(scl), .sda_pull(m_pull), .sda(sda));

    // 250 MHz clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Count take pulses, one per loaded read byte
    always @(posedge mclk) begin
        if (tx_ready === 1'b1) begin
            tx_taken <= tx_taken + 8'h01;
        end
    end

    // Inputs move 1 ns after the edge
    task automatic step(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk_byte(input string nm, input tss_byte_type e, input tss_byte_type g);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Address byte: type prefix, straps, direction
    function automatic tss_byte_type adr(input logic [2:0] s, input logic rd);
        return {`TSS_TYPE_DEFAULT, s, rd};
    endfunction

    // Bounded wait for a buffered byte, then pop it
    task automatic pop(input tss_byte_type e);
        int k;
        for (k = 0; k < 50 && rx_valid !== 1'b1; k++) begin
            step(1);
        end
        if (rx_valid !== 1'b1) begin
            fail_count++;
            conclude();
        end
        chk_byte("rx_data", e, rx_data);
        rx_ready = 1'b1;
        step(1);
        rx_ready = 1'b0;
        step(1);
    endtask

    // Fill the buffer while stalled, refuse the third byte, drain in order
    task automatic s_write;
        logic a;
        m.start();
        m.wr_byte(adr(3'h5, 1'b0), 8, a);
        chk_bit("addr ack", 1'b1, a);
        chk_bit("busy in frame", 1'b1, busy);
        m.wr_byte(8'hA5, 8, a);
        chk_bit("data ack", 1'b1, a);
        m.wr_byte(8'h3C, 8, a);
        chk_bit("second ack", 1'b1, a);
        m.wr_byte(8'h77, 8, a);
        chk_bit("full nack", 1'b0, a);
        m.stop();
        step(4);
        chk_bit("busy after stop", 1'b0, busy);
        pop(8'hA5);
        pop(8'h3C);
        chk_bit("buffer empty", 1'b0, rx_valid);
    endtask

    // Foreign address ignored; protected write refused
    task automatic s_refuse;
        logic a;
        m.start();
        m.wr_byte(adr(3'h2, 1'b0), 8, a);
        chk_bit("miss nack", 1'b0, a);
        m.wr_byte(8'h00, 8, a);
        chk_bit("ignored byte", 1'b0, a);
        m.stop();
        wp = 1'b1;
        m.start();
        m.wr_byte(adr(3'h5, 1'b0), 8, a);
        m.wr_byte(8'h11, 8, a);
        chk_bit("protect nack", 1'b0, a);
        m.stop();
        wp = 1'b0;
        chk_bit("nothing stored", 1'b0, rx_valid);
    endtask

    // Two-byte read ended by master nack; leading zeros drive both load paths
    task automatic s_read;
        logic a;
        tss_byte_type b;
        tx_data = 8'h3C;
        m.start();
        m.wr_byte(adr(3'h5, 1'b1), 8, a);
        chk_bit("read addr ack", 1'b1, a);
        m.rd_byte(b, 1'b0);
        chk_byte("read byte", 8'h3C, b);
        tx_data = 8'h69;
        m.rd_byte(b, 1'b1);
        chk_byte("second read", 8'h69, b);
        step(4);
        chk_bit("released on nack", 1'b0, sda_oe);
        chk_byte("bytes taken", 8'h02, tx_taken);
        m.stop();
        chk_bit("idle sda", 1'b1, sda);
    endtask

    // Repeated start mid-byte, then a read with nothing on offer
    task automatic s_restart;
        logic a;
        tss_byte_type b;
        tx_valid = 1'b0;
        m.start();
        m.wr_byte(adr(3'h5, 1'b0), 8, a);
        m.wr_byte(8'hE0, 3, a);
        m.start();
        m.wr_byte(adr(3'h5, 1'b1), 8, a);
        chk_bit("restart ack", 1'b1, a);
        m.rd_byte(b, 1'b1);
        chk_byte("fill byte", `TSS_FILL_BYTE, b);
        m.stop();
        chk_bit("partial dropped", 1'b0, rx_valid);
        tx_valid = 1'b1;
    endtask

    // Alarm polarity and both modes; a foreign read keeps the latch
    task automatic s_alarm;
        logic a;
        tss_byte_type b;
        evt = 1'b1;
        step(4);
        chk_bit("level low active", 1'b1, alarm_oe);
        polarity = 1'b1;
        step(4);
        chk_bit("level high active", 1'b0, alarm_oe);
        evt = 1'b0;
        step(4);
        chk_bit("level high idle", 1'b1, alarm_oe);
        polarity = 1'b0;
        mode = 1'b1;
        step(2);
        evt = 1'b1;
        step(1);
        evt = 1'b0;
        step(4);
        chk_bit("int latched", 1'b1, alarm_oe);
        m.start();
        m.wr_byte(ARA_READ, 8, a);
        chk_bit("alert poll nack", 1'b0, a);
        chk_bit("int kept", 1'b1, alarm_oe);
        m.start();
        m.wr_byte(adr(3'h5, 1'b1), 8, a);
        m.rd_byte(b, 1'b1);
        m.stop();
        step(4);
        chk_bit("int cleared", 1'b0, alarm_oe);
        mode = 1'b0;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        straps = 3'h5;
        polarity = 1'b0;
        mode = 1'b0;
        evt = 1'b0;
        wp = 1'b0;
        rx_ready = 1'b0;
        tx_valid = 1'b1;
        tx_data = 8'hC3;
        step(6);
        rst_n = 1'b1;
        step(5);
        chk_bit("alarm after reset", 1'b0, alarm_oe);
        chk_bit("sda after reset", 1'b0, sda_oe);
        chk_bit("sda value", 1'b0, sda_out);
        chk_bit("alarm value", 1'b0, alarm_out);
        s_write();
        s_refuse();
        s_read();
        s_restart();
        s_alarm();
        conclude();
    end
endmodule // tb_top

`default_nettype wire
